// *** inc/chr_link_if.sv ***
// Link between a node controller and its coax transceiver.
`timescale 1ns/1ps

interface chr_link_if;
   logic tx_n;
   logic rx_data;

   modport dev
   (
      input  tx_n,
      output rx_data
   );

   modport node
   (
      output tx_n,
      input  rx_data
   );
endinterface

// *** inc/chr_params.svh ***
// Timing and size constants for the coax hub repeater and line coder.
`ifndef CHR_PARAMS_SVH
`define CHR_PARAMS_SVH

`define CHR_CLK_NS       25
`define CHR_CELL_NS      400
`define CHR_TXP_NS       200
`define CHR_HALF_NS      100
`define CHR_QUIET_NS     4900
`define CHR_SILENCE_NS   5500
`define CHR_CLRP_NS      150

`define CHR_CELL_CYC     (`CHR_CELL_NS / `CHR_CLK_NS)
`define CHR_TXP_CYC      ((`CHR_TXP_NS + `CHR_CLK_NS - 1) / `CHR_CLK_NS)
`define CHR_HALF_CYC     ((`CHR_HALF_NS + `CHR_CLK_NS - 1) / `CHR_CLK_NS)
`define CHR_QUIET_CYC    ((`CHR_QUIET_NS + `CHR_CLK_NS - 1) / `CHR_CLK_NS)
`define CHR_SILENCE_CYC  (`CHR_SILENCE_NS / `CHR_CLK_NS)
`define CHR_CLRP_CYC     ((`CHR_CLRP_NS + `CHR_CLK_NS - 1) / `CHR_CLK_NS)

`define CHR_EMPTY_CELLS  10
`define CHR_PORTS        8
`define CHR_CNT_W        8
`define CHR_FIFO_DEPTH   2

`endif

// *** inc/chr_pkg.sv ***
// Types and shared helper functions for the coax hub repeater and line coder.
`include "chr_params.svh"

package chr_pkg;

   typedef logic [`CHR_CNT_W-1:0] chr_cnt_t;

   typedef enum logic [1:0] {
      HUB_IDLE,
      HUB_REPEAT,
      HUB_CLEAR
   } chr_hub_state_t;

   localparam chr_cnt_t PAIR_HALF = chr_cnt_t'(`CHR_HALF_CYC);
   localparam chr_cnt_t PAIR_LAST = chr_cnt_t'(2 * `CHR_HALF_CYC);

   // Advances a drive pulse pair; a trigger while a pair runs is ignored.
   function automatic chr_cnt_t chr_pair_step(input chr_cnt_t cnt, input logic trig);
      if (cnt != '0)
         chr_pair_step = (cnt == PAIR_LAST) ? '0 : chr_cnt_t'(cnt + 1'b1);
      else
         chr_pair_step = trig ? chr_cnt_t'(1) : '0;
   endfunction

   function automatic logic chr_pair_first(input chr_cnt_t cnt);
      chr_pair_first = (cnt != '0) && (cnt <= PAIR_HALF);
   endfunction

   function automatic logic chr_pair_second(input chr_cnt_t cnt);
      chr_pair_second = (cnt > PAIR_HALF);
   endfunction

endpackage

// *** logic/chr_hub.sv ***
// Transceiver line coding and active multi-port hub repeater.
`timescale 1ns/1ps
`include "chr_params.svh"

module chr_hub
   import chr_pkg::*;
#(
   parameter int PORTS = `CHR_PORTS
)
(
   input  wire logic             CLK,                  // System clock, 40 MHz.
   input  wire logic             RESETN,               // Asynchronous reset, active low.
   chr_link_if.dev               LINK,                 // Node controller side.
   input  wire logic             DETECTED_LINE_PULSE,  // Comparator pulse from local coax.
   output logic                  DRIVE_A_N,            // Local first drive pulse.
   output logic                  DRIVE_B_N,            // Local second drive pulse.
   input  wire logic [PORTS-1:0] PORT_DETECTED_PULSE,  // Comparator pulse per hub port.
   output logic      [PORTS-1:0] PORT_TX_EN,           // Port transmitter enable.
   output logic                  HUB_DRIVE_A_N,        // Hub first drive pulse.
   output logic                  HUB_DRIVE_B_N,        // Hub second drive pulse.
   output logic                  HUB_ACTIVE            // Hub is repeating.
);

   localparam chr_cnt_t CELL_LAST    = chr_cnt_t'(`CHR_CELL_CYC - 1);
   localparam chr_cnt_t EMPTY_LAST   = chr_cnt_t'(`CHR_EMPTY_CELLS - 1);
   localparam chr_cnt_t SILENCE_LAST = chr_cnt_t'(`CHR_SILENCE_CYC - 1);
   localparam chr_cnt_t CLRP_LAST    = chr_cnt_t'(`CHR_CLRP_CYC - 1);

   // Picks the lowest numbered set bit as a one-hot word.
   function automatic logic [PORTS-1:0] lowest_port(input logic [PORTS-1:0] req);
      logic [PORTS-1:0] res;
      res = '0;
      for (int i = PORTS - 1; i >= 0; i--)
         if (req[i])
            res = '0 | (PORTS'(1) << i);
      lowest_port = res;
   endfunction

   // Local line and port pulse synchronisers and edge detect.
   logic [1:0]       line_sync;
   logic             line_prev;
   logic [PORTS-1:0] port_s1;
   logic [PORTS-1:0] port_s2;
   logic [PORTS-1:0] port_prev;
   logic             tx_prev;

   wire line_edge = line_sync[1] & ~line_prev;
   wire [PORTS-1:0] port_edge = port_s2 & ~port_prev;
   wire tx_fall = tx_prev & ~LINK.tx_n;

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         line_sync <= 2'h0;
         line_prev <= 1'b0;
         port_s1   <= '0;
         port_s2   <= '0;
         port_prev <= '0;
         tx_prev   <= 1'b1;
      end
      else
      begin
         line_sync <= {line_sync[0], DETECTED_LINE_PULSE};
         line_prev <= line_sync[1];
         port_s1   <= PORT_DETECTED_PULSE;
         port_s2   <= port_s1;
         port_prev <= port_s2;
         tx_prev   <= LINK.tx_n;
      end
   end

   // Local transmit coding: one transmit pulse becomes a drive pair.
   chr_cnt_t lp_cnt;
   wire chr_cnt_t next_lp_cnt = chr_pair_step(lp_cnt, tx_fall);

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         lp_cnt    <= '0;
         DRIVE_A_N <= 1'b1;
         DRIVE_B_N <= 1'b1;
      end
      else
      begin
         lp_cnt    <= next_lp_cnt;
         DRIVE_A_N <= ~chr_pair_first(next_lp_cnt);
         DRIVE_B_N <= ~chr_pair_second(next_lp_cnt);
      end
   end

   // Local receive conversion: a cell with a pulse reads as one.
   logic     rx_busy;
   logic     rx_seen;
   logic     rx_nrz;
   chr_cnt_t rx_cnt;
   chr_cnt_t rx_empty;

   wire cell_end = rx_busy && (rx_cnt == CELL_LAST);
   wire rx_stop  = cell_end && !rx_seen && (rx_empty == EMPTY_LAST);

   assign LINK.rx_data = rx_nrz;

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         rx_busy  <= 1'b0;
         rx_seen  <= 1'b0;
         rx_nrz   <= 1'b0;
         rx_cnt   <= '0;
         rx_empty <= '0;
      end
      else if (!rx_busy)
      begin
         if (line_edge)
         begin
            rx_busy  <= 1'b1;
            rx_seen  <= 1'b1;
            rx_cnt   <= '0;
            rx_empty <= '0;
         end
      end
      else if (cell_end)
      begin
         rx_cnt   <= '0;
         rx_nrz   <= rx_seen;
         rx_seen  <= line_edge;
         rx_empty <= rx_seen ? '0 : chr_cnt_t'(rx_empty + 1'b1);
         rx_busy  <= !rx_stop;
      end
      else
      begin
         rx_cnt <= chr_cnt_t'(rx_cnt + 1'b1);
         if (line_edge)
            rx_seen <= 1'b1;
      end
   end

   // Hub repeater.
   chr_hub_state_t   state;
   logic [PORTS-1:0] act_latch;
   chr_cnt_t         sil_cnt;
   chr_cnt_t         clr_cnt;
   chr_cnt_t         hp_cnt;

   wire [PORTS-1:0] first_port = lowest_port(port_edge);
   wire any_edge    = |port_edge;
   wire sel_pulse   = |(port_edge & act_latch);
   wire start       = (state == HUB_IDLE) && any_edge;
   wire hub_trig    = start || ((state == HUB_REPEAT) && sel_pulse);
   wire sil_expire  = (state == HUB_REPEAT) && !sel_pulse && (sil_cnt == SILENCE_LAST);
   wire chr_cnt_t next_hp_cnt = chr_pair_step(hp_cnt, hub_trig);

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         state      <= HUB_IDLE;
         act_latch  <= '0;
         PORT_TX_EN <= '0;
         HUB_ACTIVE <= 1'b0;
         sil_cnt    <= '0;
         clr_cnt    <= '0;
      end
      else
      begin
         unique case (state)
            HUB_IDLE:
            begin
               sil_cnt <= '0;
               if (start)
               begin
                  act_latch  <= first_port;
                  HUB_ACTIVE <= 1'b1;
                  PORT_TX_EN <= ~first_port;
                  state      <= HUB_REPEAT;
               end
            end
            HUB_REPEAT:
            begin
               if (sel_pulse)
                  sil_cnt <= '0;
               else
                  sil_cnt <= chr_cnt_t'(sil_cnt + 1'b1);
               if (sil_expire)
               begin
                  state   <= HUB_CLEAR;
                  clr_cnt <= '0;
               end
            end
            HUB_CLEAR:
            begin
               act_latch  <= '0;
               HUB_ACTIVE <= 1'b0;
               PORT_TX_EN <= '0;
               clr_cnt    <= chr_cnt_t'(clr_cnt + 1'b1);
               if (clr_cnt == CLRP_LAST)
                  state <= HUB_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         hp_cnt        <= '0;
         HUB_DRIVE_A_N <= 1'b1;
         HUB_DRIVE_B_N <= 1'b1;
      end
      else
      begin
         hp_cnt        <= next_hp_cnt;
         HUB_DRIVE_A_N <= ~chr_pair_first(next_hp_cnt);
         HUB_DRIVE_B_N <= ~chr_pair_second(next_hp_cnt);
      end
   end

endmodule // chr_hub

// *** logic/chr_node.sv ***
// Node controller end: bit serialiser with a two-entry buffer and NRZ receiver.
`timescale 1ns/1ps
`include "chr_params.svh"

module chr_node
   import chr_pkg::*;
#(
   parameter int WIDTH = 1,
   parameter int DEPTH = `CHR_FIFO_DEPTH
)
(
   input  wire logic             CLK,       // System clock, 40 MHz.
   input  wire logic             RESETN,    // Asynchronous reset, active low.
   chr_link_if.node              LINK,      // Transceiver side.
   input  wire logic [WIDTH-1:0] TX_BIT,    // Bit to send.
   input  wire logic             TX_VALID,  // TX_BIT is valid.
   output logic                  TX_READY,  // Buffer can take a bit.
   output logic                  RX_BIT,    // Received bit.
   output logic                  RX_VALID,  // RX_BIT valid for one cycle.
   output logic                  RX_BUSY    // Reception in progress.
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam chr_cnt_t CELL_LAST  = chr_cnt_t'(`CHR_CELL_CYC - 1);
   localparam chr_cnt_t MID_CELL   = chr_cnt_t'(`CHR_CELL_CYC / 2 - 1);
   localparam chr_cnt_t TXP_CYC    = chr_cnt_t'(`CHR_TXP_CYC);
   localparam chr_cnt_t EMPTY_LAST = chr_cnt_t'(`CHR_EMPTY_CELLS - 1);

   logic [WIDTH-1:0] fifo_mem [DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [CW-1:0]    count;
   logic             tx_on;
   logic             tx_one;
   chr_cnt_t         tx_cnt;
   logic             tx_n;

   wire push     = TX_VALID && TX_READY;
   wire pop      = (count != '0) && (!tx_on || (tx_cnt == CELL_LAST));
   wire head_bit = fifo_mem[rd_ptr][0];
   wire [CW-1:0] next_count = CW'(count + CW'(push) - CW'(pop));
   wire [PW-1:0] next_wr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr + 1'b1);
   wire [PW-1:0] next_rd = (rd_ptr == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr + 1'b1);
   wire chr_cnt_t next_tx_cnt = chr_cnt_t'(tx_cnt + 1'b1);

   assign LINK.tx_n = tx_n;

   always_ff @(posedge CLK)
   begin
      if (push)
         fifo_mem[wr_ptr] <= TX_BIT;
   end

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         wr_ptr   <= '0;
         rd_ptr   <= '0;
         count    <= '0;
         TX_READY <= 1'b0;
      end
      else
      begin
         if (push)
            wr_ptr <= next_wr;
         if (pop)
            rd_ptr <= next_rd;
         count    <= next_count;
         TX_READY <= (next_count != CW'(DEPTH));
      end
   end

   // One bit per 400 ns cell; a one is a 200 ns low pulse at cell start.
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         tx_on  <= 1'b0;
         tx_one <= 1'b0;
         tx_cnt <= '0;
         tx_n   <= 1'b1;
      end
      else if (pop)
      begin
         tx_on  <= 1'b1;
         tx_one <= head_bit;
         tx_cnt <= '0;
         tx_n   <= ~head_bit;
      end
      else if (tx_on && (tx_cnt == CELL_LAST))
      begin
         tx_on <= 1'b0;
         tx_n  <= 1'b1;
      end
      else if (tx_on)
      begin
         tx_cnt <= next_tx_cnt;
         tx_n   <= ~(tx_one && (next_tx_cnt < TXP_CYC));
      end
   end

   // Receiver: samples NRZ data mid cell after the first rising edge.
   logic     rx_prev;
   chr_cnt_t rx_cnt;
   chr_cnt_t rx_zero;

   wire rx_rise = LINK.rx_data && !rx_prev;
   wire rx_mid  = RX_BUSY && (rx_cnt == MID_CELL);

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         rx_prev  <= 1'b0;
         rx_cnt   <= '0;
         rx_zero  <= '0;
         RX_BUSY  <= 1'b0;
         RX_BIT   <= 1'b0;
         RX_VALID <= 1'b0;
      end
      else
      begin
         rx_prev  <= LINK.rx_data;
         RX_VALID <= rx_mid;
         if (!RX_BUSY)
         begin
            RX_BUSY <= rx_rise;
            rx_cnt  <= '0;
            rx_zero <= '0;
         end
         else
         begin
            rx_cnt <= (rx_cnt == CELL_LAST) ? '0 : chr_cnt_t'(rx_cnt + 1'b1);
            if (rx_mid)
            begin
               RX_BIT  <= LINK.rx_data;
               rx_zero <= LINK.rx_data ? '0 : chr_cnt_t'(rx_zero + 1'b1);
               if (!LINK.rx_data && (rx_zero == EMPTY_LAST))
                  RX_BUSY <= 1'b0;
            end
         end
      end
   end

endmodule // chr_node

// *** verif/chr_link_checker.sv ***
// Concurrent checks on the node link and the hub outputs.
`timescale 1ns/1ps

module chr_link_checker
#(
   parameter int PORTS = 8
)
(
   input wire logic             CLK,           // System clock.
   input wire logic             RESETN,        // Reset, active low.
   input wire logic             tx_n,          // Node transmit pulse.
   input wire logic             rx_data,       // NRZ receive data.
   input wire logic             DRIVE_A_N,     // Local first drive.
   input wire logic             DRIVE_B_N,     // Local second drive.
   input wire logic [PORTS-1:0] PORT_TX_EN,    // Port transmitter enables.
   input wire logic             HUB_DRIVE_A_N, // Hub first drive.
   input wire logic             HUB_DRIVE_B_N, // Hub second drive.
   input wire logic             HUB_ACTIVE     // Hub repeating.
);
   logic       prev_a;
   logic [7:0] quiet;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);

   // Cycles since the hub last started a drive pair.
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         prev_a <= 1'b1;
         quiet  <= 8'h00;
      end
      else
      begin
         prev_a <= HUB_DRIVE_A_N;
         quiet  <= (prev_a && !HUB_DRIVE_A_N) ? 8'h00 : quiet + {7'h00, quiet != 8'hFF};
      end
   end

   AST_TX_LOW: assert property ($fell(tx_n) |-> (!tx_n)[*8] ##1 tx_n)
      else $error("node pulse is not eight cycles low");
   AST_TX_PAIR: assert property ($fell(tx_n) && DRIVE_A_N && DRIVE_B_N |=>
      (!DRIVE_A_N && DRIVE_B_N)[*4] ##1 (DRIVE_A_N && !DRIVE_B_N)[*4] ##1 DRIVE_B_N)
      else $error("local drive pair malformed");
   AST_RX_CELL: assert property ($changed(rx_data) |=> $stable(rx_data)[*8])
      else $error("receive data changed inside a cell");
   AST_IDLE_OFF: assert property (!HUB_ACTIVE |-> PORT_TX_EN == '0)
      else $error("transmitter enabled while idle");
   AST_SEL_ONE: assert property (HUB_ACTIVE |-> $countones(~PORT_TX_EN) == 1)
      else $error("not exactly one port held silent");
   AST_SEL_HOLD: assert property (HUB_ACTIVE && $past(HUB_ACTIVE) |-> $stable(PORT_TX_EN))
      else $error("selection changed while repeating");
   AST_HUB_PAIR: assert property ($fell(HUB_DRIVE_A_N) |-> HUB_ACTIVE && HUB_DRIVE_B_N
      ##1 (!HUB_DRIVE_A_N)[*3] ##1 (HUB_DRIVE_A_N && !HUB_DRIVE_B_N)[*4] ##1 HUB_DRIVE_B_N)
      else $error("hub drive pair malformed");
   AST_QUIET: assert property ($fell(HUB_ACTIVE) |-> quiet >= 8'hC5 && quiet <= 8'hE6)
      else $error("hub left repeating at wrong silence");
   AST_CLEAR: assert property ($fell(HUB_ACTIVE) |-> (PORT_TX_EN == '0 && !HUB_ACTIVE)[*6])
      else $error("clear period too short");

   cover property ($rose(HUB_ACTIVE));
   cover property ($fell(rx_data));
   cover property ($fell(DRIVE_B_N));
endmodule // chr_link_checker

// *** verif/testbench.sv ***
// Self-checking testbench joining the node end and the hub end over one link.
`timescale 1ns/1ps

module testbench;
   logic       clk      = 1'b0;
   logic       resetn   = 1'b0;
   logic [0:0] tx_bit   = 1'b0;
   logic       tx_valid = 1'b0;
   logic       det      = 1'b0;
   logic [7:0] port_det = 8'h00;
   logic       tx_ready, rx_bit, rx_valid, rx_busy, hub_active;
   logic       drv_a_n, drv_b_n, hub_a_n, hub_b_n;
   logic       pa = 1'b1, pb = 1'b1, ph = 1'b1, phb = 1'b1, full_seen = 1'b0;
   logic [7:0] port_tx_en;
   logic [7:0] rx_bits = 8'h00;
   int         n_errors = 0;
   int         cmp_count = 0;
   int         cyc = 0;
   int         a_falls = 0, b_falls = 0, h_falls = 0, hb_falls = 0, rx_n = 0;

   chr_link_if link();

   chr_node i_chr_node (.CLK(clk), .RESETN(resetn), .LINK(link.node), .TX_BIT(tx_bit),
      .TX_VALID(tx_valid), .TX_READY(tx_ready), .RX_BIT(rx_bit), .RX_VALID(rx_valid),
      .RX_BUSY(rx_busy));
   chr_hub i_chr_hub (.CLK(clk), .RESETN(resetn), .LINK(link.dev), .DETECTED_LINE_PULSE(det),
      .DRIVE_A_N(drv_a_n), .DRIVE_B_N(drv_b_n), .PORT_DETECTED_PULSE(port_det),
      .PORT_TX_EN(port_tx_en), .HUB_DRIVE_A_N(hub_a_n), .HUB_DRIVE_B_N(hub_b_n),
      .HUB_ACTIVE(hub_active));
   chr_link_checker #(.PORTS(8)) i_chr_link_checker (.CLK(clk), .RESETN(resetn),
      .tx_n(link.tx_n), .rx_data(link.rx_data), .DRIVE_A_N(drv_a_n), .DRIVE_B_N(drv_b_n),
      .PORT_TX_EN(port_tx_en), .HUB_DRIVE_A_N(hub_a_n), .HUB_DRIVE_B_N(hub_b_n),
      .HUB_ACTIVE(hub_active));

   always #12.5 clk = ~clk;

   // Monitors sample settled values at the falling edge.
   always @(negedge clk)
   begin
      a_falls += int'(pa && !drv_a_n);
      b_falls += int'(pb && !drv_b_n);
      h_falls += int'(ph && !hub_a_n);
      hb_falls += int'(phb && !hub_b_n);
      pa = drv_a_n;
      pb = drv_b_n;
      ph = hub_a_n;
      phb = hub_b_n;
      if (tx_valid && tx_ready === 1'b0)
         full_seen = 1'b1;
      if (rx_valid === 1'b1 && rx_n < 8)
      begin
         rx_bits = {rx_bits[6:0], rx_bit};
         rx_n++;
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         tally_and_finish();
      end
   end

   // Holds the given comparator pins high for three cycles, then waits out the gap.
   task automatic pulse(input logic [7:0] m, input logic d, input int gap);
      port_det = m;
      det      = d;
      repeat (3) @(negedge clk);
      port_det = 8'h00;
      det      = 1'b0;
      repeat (gap - 3) @(negedge clk);
   endtask

   task automatic push(input logic b);
      tx_bit   = b;
      tx_valid = 1'b1;
      while (tx_ready !== 1'b1) @(negedge clk);
      @(negedge clk);
   endtask

   task automatic t_node_tx();
      logic [3:0] bits;
      bits = 4'b1101;
      a_falls = 0;
      b_falls = 0;
      foreach (bits[i]) push(bits[i]);
      tx_valid = 1'b0;
      repeat (96) @(negedge clk);
      check(8'(a_falls), 8'h03, "first drive pulses");
      check(8'(b_falls), 8'h03, "second drive pulses");
      check({7'h00, full_seen}, 8'h01, "buffer refusal");
      $display("node transmit test done");
   endtask

   task automatic t_rx();
      logic [7:0] pat;
      int         n;
      pat  = 8'hB2;
      rx_n = 0;
      for (int i = 7; i >= 0; i--) pulse(8'h00, pat[i], 16);
      n = 0;
      while (rx_busy !== 1'b0 && n < 400)
      begin
         @(negedge clk);
         n++;
      end
      repeat (200) @(negedge clk);
      check(rx_bits, pat, "received bits");
      check({7'h00, link.rx_data}, 8'h00, "receive rests low");
      check({7'h00, rx_busy}, 8'h00, "reception ended");
      $display("receive test done");
   endtask

   task automatic t_hub(input int p);
      logic [7:0] sel;
      int         gaps[3];
      int         n;
      sel  = 8'h01 << p;
      gaps = '{160, 16, 16};
      h_falls = 0;
      hb_falls = 0;
      check(port_tx_en, 8'h00, "idle enables");
      pulse(sel | 8'h80, 1'b0, 16);
      check(port_tx_en, ~sel, "selection");
      check({7'h00, hub_active}, 8'h01, "hub active");
      pulse(8'h01 << ((p + 1) % 8), 1'b0, 16);
      check(port_tx_en, ~sel, "selection kept");
      foreach (gaps[i]) pulse(sel, 1'b0, gaps[i]);
      check({7'h00, hub_active}, 8'h01, "active across gap");
      check(8'(h_falls), 8'h04, "repeated pairs");
      check(8'(hb_falls), 8'h04, "repeated second pulses");
      n = 16;
      while (hub_active !== 1'b0 && n < 300)
      begin
         @(negedge clk);
         n++;
      end
      check({7'h00, n >= 197 && n <= 235}, 8'h01, "silence timeout");
      check(port_tx_en, 8'h00, "cleared enables");
      repeat (490) @(negedge clk);
      $display("hub test on port %0d done", p);
   endtask

   // Resets the hub while it repeats, then shows that a fresh start works.
   task automatic t_reset();
      pulse(8'h08, 1'b0, 16);
      check(port_tx_en, 8'hF7, "active before reset");
      resetn = 1'b0;
      @(negedge clk);
      check(port_tx_en, 8'h00, "enables in reset");
      check({7'h00, hub_active}, 8'h00, "idle in reset");
      repeat (3) @(negedge clk);
      resetn = 1'b1;
      repeat (2) @(negedge clk);
      pulse(8'h20, 1'b0, 16);
      check(port_tx_en, 8'hDF, "selection after reset");
      $display("mid-run reset test done");
   endtask

   initial
   begin
      repeat (4) @(negedge clk);
      resetn = 1'b1;
      repeat (2) @(negedge clk);
      t_node_tx();
      t_rx();
      for (int p = 0; p < 8; p++) t_hub(p);
      t_reset();
      tally_and_finish();
   end
endmodule // testbench
